// file: mpr_pkg.sv
package mpr_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFF_SELECT = 8'h00;
  localparam logic [7:0] OFF_BASE   = 8'h04;
  localparam logic [7:0] OFF_ATTR   = 8'h08;

  // Base register layout
  localparam int BASE_FLAG_BIT  = 4;
  localparam int BASE_REG_MSB   = 3;
  localparam int ADDR_LSB       = 5;
  localparam int SELECT_MSB     = 7;

  // Attribute/size register layout
  localparam int XN_BIT        = 28;
  localparam int AP_MSB        = 26;
  localparam int AP_LSB        = 24;
  localparam int SRD_MSB       = 15;
  localparam int SRD_LSB       = 8;
  localparam int SIZE_MSB      = 5;
  localparam int SIZE_LSB      = 1;
  localparam int EN_BIT        = 0;
  localparam logic [31:0] ATTR_WMASK = 32'h173f_ff3f;
  localparam logic [31:0] BASE_WMASK = 32'hffff_ffe0;

  // Size encodings
  localparam logic [4:0] SIZE_MIN    = 5'h04;
  localparam logic [4:0] SIZE_SUBREG = 5'h07;
  localparam logic [4:0] SIZE_FULL   = 5'h1f;
  localparam logic [5:0] N_MIN       = 6'h05;
  localparam logic [5:0] SUBREG_BITS = 6'h03;

  // Permission codes
  localparam logic [2:0] AP_NONE    = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL    = 3'h3;
  localparam logic [2:0] AP_RSVD    = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO_A    = 3'h6;
  localparam logic [2:0] AP_RO_B    = 3'h7;

  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage : mpr_pkg

// file: mpr_region_regs.sv
`timescale 1ns/100ps
// How it works
// - Base write with flag set loads region select, then stores base there.
// - Base write with flag clear keeps select and stores to current region.
// - Base register flag bit always reads back zero.
// - Base register read shows current region select in low four bits.
// - Base held in bits 31..N; bits N-1..5 read zero.
// - A 32-byte region uses bits 31..5 as base.
// - Full 4GB region has no base and covers everything.
// - Attribute register takes word or halfword writes via byte enables.
// - Execute-never blocks instruction fetches from the region.
// - Permission code in bits 26..24 sets region access rights.
// - Type extension, shareable, cacheable, bufferable held in bits 21..16.
// - Each subregion-disable bit set switches off its subregion in regions of 256 bytes or more.
// - Only enabled regions take part in checks.
// - Region spans two to the power size plus one bytes; sizes below 4 give 32 bytes.
// - Code 000 denies all; 011 grants full access.
// - A permission violation raises the memory fault.
module mpr_region_regs
  import mpr_pkg::*;
#(
  parameter int NREG = 8
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic [3:0]  regWrBe,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [31:0] regRdData,
  input  wire logic        protEnable,
  input  wire logic        privDefault,
  input  wire logic        chkValid,
  input  wire logic [31:0] chkAddr,
  input  wire logic        chkPriv,
  input  wire logic        chkWrite,
  input  wire logic        chkFetch,
  output logic      [7:0]  regionSel,
  output logic             memoryFault,
  output logic             chkHit,
  output logic      [7:0]  chkRegion
);

  // Region index width; one bit kept even for a single region
  // Select register stays eight bits wide for software, but only
  // the low index bits address storage, so high values alias
  localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

  // Per-region storage, reserved bits never stored
  logic [31:0] baseQ [NREG];
  logic [31:0] baseD [NREG];
  logic [31:0] attrQ [NREG];
  logic [31:0] attrD [NREG];
  logic [7:0]  selQ;
  logic [7:0]  selD;
  logic [31:0] rdQ;
  logic [31:0] rdD;
  logic        faultQ;
  logic        faultD;
  logic        hitQ;
  logic        hitD;
  logic [7:0]  hitRegQ;
  logic [7:0]  hitRegD;

  logic [IW-1:0] curIdx;
  logic [IW-1:0] tgtIdx;
  logic [7:0]    newSel;
  logic [31:0]   wrMask;
  logic [NREG-1:0] regHit;

  // Sizes below the minimum are clamped to the smallest region,
  // so a bad size field never opens up the whole address map.
  // The full size has no base at all and matches every address.
  // Shared by the read path and the per-region match logic
  // Bits at and above N, for N from the size field
  function automatic logic [31:0] base_mask(input logic [4:0] sz);
    logic [5:0]  n;
    logic [31:0] m;
    n = (sz < SIZE_MIN) ? N_MIN : {1'b0, sz} + 6'h01;
    m = '0;
    for (int b = 0; b < 32; b++) begin
      m[b] = (6'(b) >= n);
    end
    if (sz == SIZE_FULL) begin
      m = '0;
    end
    return m;
  endfunction : base_mask

  // Reads are allowed wherever writes are; read-only codes
  // only block the write direction, except 101, which also denies user reads.
  // Reserved code is denied so that a misprogrammed region
  // fails closed instead of granting access
  // Permission decode by privilege and direction
  function automatic logic perm_ok(input logic [2:0] ap,
                                   input logic priv,
                                   input logic wr);
    logic ok;
    case (ap)
      AP_NONE:    ok = 1'b0;
      AP_PRIV_RW: ok = priv;
      AP_USER_RO: ok = priv | ~wr;
      AP_FULL:    ok = 1'b1;
      AP_RSVD:    ok = 1'b0; // Unpredictable code, denied for safety
      AP_PRIV_RO: ok = priv & ~wr;
      AP_RO_A:    ok = ~wr;
      AP_RO_B:    ok = ~wr;
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction : perm_ok

  // Lanes are independent, so attributes and size can be
  // programmed by two halfword stores in either order
  // Byte-lane write mask, halfword writes keep the other half
  always_comb begin
    wrMask = '0;
    for (int k = 0; k < 4; k++) begin
      wrMask[k*8 +: 8] = {8{regWrBe[k]}};
    end
  end

  // The flag must arrive in lane zero; an upper-half write
  // cannot retarget the select register by accident.
  // Target is picked before the store so the base lands in
  // the newly selected region in the same cycle
  // Region select and write target
  always_comb begin
    curIdx = selQ[IW-1:0];
    newSel = {{(7-BASE_REG_MSB){1'b0}}, regWrData[BASE_REG_MSB:0]};
    if (regWrEn && regAddr == OFF_BASE && regWrBe[0] && regWrData[BASE_FLAG_BIT]) begin
      tgtIdx = newSel[IW-1:0];
    end else begin
      tgtIdx = curIdx;
    end
  end

  // All storage holds its value unless a write hits it.
  // Reserved positions are masked on the way in, so reads
  // never have to scrub stale data from them.
  // Unmapped offsets leave every register untouched
  // Next values for select and region storage
  always_comb begin
    selD = selQ;
    for (int r = 0; r < NREG; r++) begin
      baseD[r] = baseQ[r];
      attrD[r] = attrQ[r];
    end
    if (regWrEn) begin
      case (regAddr)
        OFF_SELECT: begin
          if (regWrBe[0]) begin
            selD = regWrData[SELECT_MSB:0];
          end
        end
        OFF_BASE: begin
          if (regWrBe[0] && regWrData[BASE_FLAG_BIT]) begin
            selD = newSel;
          end
          // Region field ignored when flag clear
          baseD[tgtIdx] = (baseQ[tgtIdx] & ~(wrMask & BASE_WMASK))
                        | (regWrData & wrMask & BASE_WMASK);
        end
        OFF_ATTR: begin
          attrD[curIdx] = (attrQ[curIdx] & ~(wrMask & ATTR_WMASK))
                        | (regWrData & wrMask & ATTR_WMASK);
        end
        default: begin
          selD = selQ; // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Idle cycles return zero so a stale word cannot be
  // mistaken for a fresh answer by the bus master.
  // Base read hides bits below N, which depend on the size
  // field of the same region; a size change alters them
  // Read data, presented the cycle after the strobe
  always_comb begin
    rdD = '0;
    if (regRdEn) begin
      case (regAddr)
        OFF_SELECT: rdD = {24'h00_0000, selQ};
        OFF_BASE: begin
          rdD = baseQ[curIdx] & base_mask(attrQ[curIdx][SIZE_MSB:SIZE_LSB]);
          rdD[BASE_FLAG_BIT] = 1'b0;
          rdD[BASE_REG_MSB:0] = selQ[BASE_REG_MSB:0];
        end
        OFF_ATTR: rdD = attrQ[curIdx] & ATTR_WMASK;
        default:  rdD = '0;
      endcase
    end
  end

  // Each region compares the address above its own N.
  // Subregion index is the three bits just below N; regions
  // too small for subregions ignore the disable mask.
  // Misaligned bases simply match on the masked bits only,
  // so software alignment is assumed, not checked here
  // Per-region address match
  generate
    for (genvar g = 0; g < NREG; g++) begin : gRegion
      logic [4:0]  sz;
      logic [31:0] msk;
      logic [5:0]  n;
      logic [5:0]  sh;
      logic [31:0] shifted;
      logic [2:0]  sub;
      logic        subOff;
      always_comb begin
        sz = attrQ[g][SIZE_MSB:SIZE_LSB];
        msk = base_mask(sz);
        n = (sz < SIZE_MIN) ? N_MIN : {1'b0, sz} + 6'h01;
        sh = n - SUBREG_BITS;
        shifted = chkAddr >> sh;
        sub = shifted[2:0];
        // Small regions have no subregions
        subOff = (sz >= SIZE_SUBREG) && attrQ[g][SRD_LSB + 32'(sub)];
        regHit[g] = attrQ[g][EN_BIT]
                  && (((chkAddr ^ baseQ[g]) & msk) == 32'h0000_0000)
                  && !subOff;
      end
    end
  endgenerate

  // Overlaps are legal; the last hit in the loop wins, which
  // lets software layer a small region over a large one.
  // With no hit, only privileged accesses may fall back to
  // the background map, and only when it is switched on.
  // Fault is suppressed entirely while protection is off
  // Highest numbered matching region wins, then permissions
  always_comb begin
    logic         found;
    logic [IW-1:0] win;
    logic         ok;
    found = 1'b0;
    win = '0;
    ok = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      if (regHit[r]) begin
        found = 1'b1;
        win = IW'(r);
      end
    end
    if (found) begin
      ok = perm_ok(attrQ[win][AP_MSB:AP_LSB], chkPriv, chkWrite)
         && !(chkFetch && attrQ[win][XN_BIT]);
    end else begin
      ok = privDefault && chkPriv; // Background map, privileged only
    end
    faultD = chkValid && protEnable && !ok;
    hitD = chkValid && found;
    hitRegD = hitRegQ;
    if (chkValid) begin
      hitRegD = 8'(win);
    end
  end

  // Synchronous reset clears every region, so all regions
  // start disabled and the check path sees no stray hits.
  // Only constants appear in the reset branch
  // Registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selQ    <= REG_RESET[7:0];
      rdQ     <= REG_RESET;
      faultQ  <= 1'b0;
      hitQ    <= 1'b0;
      hitRegQ <= REG_RESET[7:0];
      for (int r = 0; r < NREG; r++) begin
        baseQ[r] <= REG_RESET;
        attrQ[r] <= REG_RESET;
      end
    end else begin
      selQ    <= selD;
      rdQ     <= rdD;
      faultQ  <= faultD;
      hitQ    <= hitD;
      hitRegQ <= hitRegD;
      for (int r = 0; r < NREG; r++) begin
        baseQ[r] <= baseD[r];
        attrQ[r] <= attrD[r];
      end
    end
  end

  // Check results lag the request by one cycle; the fault
  // pulse stands for exactly one cycle per violating check
  // Outputs straight from flops
  assign regRdData   = rdQ;
  assign regionSel   = selQ;
  assign memoryFault = faultQ;
  assign chkHit      = hitQ;
  assign chkRegion   = hitRegQ;

endmodule : mpr_region_regs

// file: mpr_region_regs_properties.sv
`timescale 1ns/100ps
module mpr_region_regs_properties
  import mpr_pkg::*;
#(
  parameter int NREG = 8
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [3:0]  regWrBe,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic        protEnable,
  input wire logic        chkValid,
  input wire logic [7:0]  regionSel,
  input wire logic        memoryFault,
  input wire logic        chkHit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Decoded strobes, kept apart so the properties stay short
  wire logic baseRd = regRdEn && regAddr == OFF_BASE;
  wire logic baseWr = regWrEn && regAddr == OFF_BASE;
  wire logic badAdr = regAddr != OFF_SELECT && regAddr != OFF_BASE && regAddr != OFF_ATTR;

  read_idle_a: assert property (!regRdEn |=> regRdData == 32'h0)
    else $error("read data not idle");
  flag_zero_a: assert property (baseRd |=> !regRdData[4])
    else $error("flag bit read back set");
  sel_read_a: assert property (baseRd |=> regRdData[3:0] == $past(regionSel[3:0]))
    else $error("base read lacks region select");
  sel_load_a: assert property (baseWr && regWrData[4] && regWrBe[0]
    |=> regionSel[2:0] == $past(regWrData[2:0])) else $error("select not loaded");
  sel_keep_a: assert property (baseWr && !regWrData[4] |=> $stable(regionSel))
    else $error("select changed on flag clear");
  attr_rsvd_a: assert property (regRdEn && regAddr == OFF_ATTR
    |=> (regRdData & ~ATTR_WMASK) == 32'h0) else $error("attr reserved bits set");
  unmapped_zero_a: assert property (regRdEn && badAdr |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  fault_off_a: assert property (!protEnable |=> !memoryFault)
    else $error("fault while protection off");
  check_idle_a: assert property (!chkValid |=> !memoryFault && !chkHit)
    else $error("check result without request");

  cover property (baseWr && regWrData[4]);
  cover property (memoryFault);
  cover property (chkHit);
endmodule : mpr_region_regs_properties

bind mpr_region_regs mpr_region_regs_properties #(.NREG(NREG)) chk_u (.core_clk,
  .sys_rst, .regAddr, .regWrData, .regWrBe, .regWrEn, .regRdEn, .regRdData,
  .protEnable, .chkValid, .regionSel, .memoryFault, .chkHit);

// file: testbench.sv
`timescale 1ns/100ps
module testbench
  import mpr_pkg::*;
;
  logic        core_clk = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic        protEnable = 1'b1, privDefault = 1'b0, chkValid = 1'b0;
  logic        chkPriv = 1'b0, chkWrite = 1'b0, chkFetch = 1'b0, memoryFault, chkHit;
  logic [7:0]  regAddr = 8'h00, regionSel, chkRegion;
  logic [3:0]  regWrBe = 4'h0;
  logic [31:0] regWrData = 32'h0, chkAddr = 32'h0, regRdData;
  int          errCount = 0, samplesChecked = 0;
  // Faulting mask per code: bit0 user rd, bit1 user wr, bit2 priv rd, bit3 priv wr
  logic [3:0]  apFault [8] = '{4'hf, 4'h3, 4'h2, 4'h0, 4'hf, 4'hb, 4'ha, 4'ha};

  mpr_region_regs #(.NREG(8)) dut_u (.core_clk, .sys_rst, .regAddr, .regWrData,
    .regWrBe, .regWrEn, .regRdEn, .regRdData, .protEnable, .privDefault, .chkValid,
    .chkAddr, .chkPriv, .chkWrite, .chkFetch, .regionSel, .memoryFault, .chkHit,
    .chkRegion);

  // Free-running core clock
  always #12.5 core_clk = ~core_clk;

  task end_sim;
    $display("errors %0d checks %0d", errCount, samplesChecked);
    if (errCount == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // Extra idle edge so a strobe is never lowered and raised in one step
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    regAddr <= a;
    regWrData <= d;
    regWrBe <= b;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 cmp(regRdData, e);
    @(posedge core_clk);
  endtask : rd

  // Expectation is {fault, hit, region}; region only judged on a hit
  task chk(input logic [31:0] a, input logic [2:0] pwf, input logic [9:0] e);
    chkAddr <= a;
    {chkPriv, chkWrite, chkFetch} <= pwf;
    chkValid <= 1'b1;
    @(posedge core_clk);
    chkValid <= 1'b0;
    #1 cmp({memoryFault, chkHit}, e[9:8]);
    if (e[8]) cmp(chkRegion, e[7:0]);
    @(posedge core_clk);
  endtask : chk

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFF_ATTR, 32'h0);
    wr(OFF_SELECT, 32'h2, 4'hf);
    wr(OFF_BASE, 32'h2000_0013, 4'hf);
    cmp(regionSel, 32'h3);
    wr(OFF_ATTR, 32'hffff_0013, 4'h3);
    wr(OFF_ATTR, 32'heb5f_ffff, 4'hc);
    rd(OFF_ATTR, 32'h031f_0013);
    wr(OFF_BASE, 32'h2000_03e5, 4'hf);
    rd(OFF_BASE, 32'h2000_0003);
    rd(8'h0c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_ATTR, {5'h0, i[2:0], 24'h0}, 4'hc);
      for (int j = 0; j < 4; j++)
        chk(32'h2000_0010, {j[1:0], 1'b0}, {apFault[i][j], 9'h103});
    end
    wr(OFF_ATTR, 32'h1300_0000, 4'hc);
    chk(32'h2000_0010, 3'b001, {2'b11, 8'h3});
    wr(OFF_ATTR, 32'h0000_0413, 4'h3);
    chk(32'h2000_0100, 3'b000, {2'b10, 8'h0});
    chk(32'h2000_0080, 3'b000, {2'b01, 8'h3});
    wr(OFF_ATTR, 32'h0000_0012, 4'h3);
    chk(32'h2000_0080, 3'b000, {2'b10, 8'h0});
    privDefault <= 1'b1;
    chk(32'h2000_0080, 3'b100, {2'b00, 8'h0});
    wr(OFF_BASE, 32'hf000_0015, 4'hf);
    wr(OFF_ATTR, 32'h0300_003f, 4'hf);
    rd(OFF_BASE, 32'h0000_0005);
    chk(32'h0000_1000, 3'b010, {2'b01, 8'h5});
    wr(OFF_BASE, 32'h4000_0036, 4'hf);
    wr(OFF_ATTR, 32'h0300_0009, 4'hf);
    rd(OFF_BASE, 32'h4000_0026);
    wr(OFF_SELECT, 32'h5, 4'hf);
    wr(OFF_ATTR, 32'h0300_0000, 4'hf);
    chk(32'h4000_003c, 3'b010, {2'b01, 8'h6});
    chk(32'h4000_0040, 3'b010, {2'b10, 8'h0});
    protEnable <= 1'b0;
    chk(32'h4000_0040, 3'b010, {2'b00, 8'h0});
    end_sim;
  end
endmodule : testbench
